/* File: common/ssc_pkg.sv */
// Constants and types for the synchronous serial channel
package ssc_pkg;
	localparam logic [2:0] ADDR_MODE = 3'h0;
	localparam logic [2:0] ADDR_BAUD = 3'h1;
	localparam logic [2:0] ADDR_CTRL = 3'h2;
	localparam logic [2:0] ADDR_TXB = 3'h3;
	localparam logic [2:0] ADDR_RXB = 3'h4;
	localparam logic [2:0] ADDR_STAT = 3'h5;
	localparam logic [2:0] ADDR_MASK = 3'h6;
	// Mode bits
	localparam int MODE_CLOCK_DIRECTION_SELECT_BIT = 0;
	localparam int MODE_SRC_LSB = 1;
	localparam int MODE_POL_BIT = 3;
	localparam int MODE_MSB_BIT = 4;
	localparam int MODE_CONT_BIT = 5;
	// Control bits
	localparam int CTRL_TXEN_BIT = 0;
	localparam int CTRL_RXEN_BIT = 1;
	localparam int CTRL_IRS_BIT = 2;
	// Status bits
	localparam int ST_TX_BIT = 0;
	localparam int ST_RX_BIT = 1;
	localparam int ST_OVR_BIT = 2;
	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam logic [7:0] BAUD_RESET = 8'h00;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [3:0] FRAME_BITS = 4'h8;
	localparam logic [3:0] OVR_BIT_NUM = 4'h7;
	localparam logic [5:0] PRE_DIV8 = 6'h07;
	localparam logic [5:0] PRE_DIV32 = 6'h1F;
	typedef enum logic [1:0]
	{
		SSC_IDLE = 2'b00,
		SSC_LOAD = 2'b01,
		SSC_SHIFT = 2'b10
	} ssc_state_e;
endpackage : ssc_pkg

/* File: hdl/ssc_channel.sv */
// Synchronous serial channel, clock synchronous mode
//
// The placing of the registers and the plain strobed port were decided locally.
`timescale 1ns/1ns
`default_nettype none
module ssc_channel
(
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic [2:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	input wire logic i_sclk_in,
	output logic o_sclk_out,
	output logic o_sclk_oe,
	input wire logic i_rxd,
	output logic o_txd,
	output logic o_irq
);
	import ssc_pkg::*;

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [7:0] mode_ff, baud_ff, ctrl_ff, txb_ff, rxb_ff, sts_ff, mask_ff, rdata_ff;
	logic tx_empty_ff, rx_full_ff, cont_arm_ff;
	logic [7:0] txsh_ff, rxsh_ff;
	logic [3:0] bitcnt_ff;
	logic [5:0] pre_ff;
	logic [7:0] brg_ff;
	logic sclk_ff, txd_ff, irq_ff, sclk_oe_ff;
	logic [2:0] pin_ff;
	ssc_state_e state_ff;

	wire wr_mode = i_wr && i_addr == ADDR_MODE;
	wire wr_baud = i_wr && i_addr == ADDR_BAUD;
	wire wr_ctrl = i_wr && i_addr == ADDR_CTRL;
	wire wr_txb = i_wr && i_addr == ADDR_TXB;
	wire wr_stat = i_wr && i_addr == ADDR_STAT;
	wire wr_mask = i_wr && i_addr == ADDR_MASK;
	wire rd_rxb = i_rd && i_addr == ADDR_RXB;

	wire ext_clk = mode_ff[MODE_CLOCK_DIRECTION_SELECT_BIT];
	wire [1:0] src_sel = mode_ff[MODE_SRC_LSB +: 2];
	wire pol = mode_ff[MODE_POL_BIT];
	wire msb_first = mode_ff[MODE_MSB_BIT];
	wire cont_rx = mode_ff[MODE_CONT_BIT];
	wire tx_en = ctrl_ff[CTRL_TXEN_BIT];
	wire rx_en = ctrl_ff[CTRL_RXEN_BIT];
	wire irs = ctrl_ff[CTRL_IRS_BIT];
	wire idle_lvl = ~pol;

	// ----------------------------------------
	// Internal clock: prescaler and divider
	// ----------------------------------------
	// Source 0 is f1, 1 is f8, else f32
	wire [5:0] pre_max = (src_sel == 2'h0) ? 6'h00 : (src_sel == 2'h1) ? PRE_DIV8 : PRE_DIV32;
	wire pre_tick = (pre_ff >= pre_max);
	// Each half period lasts n+1 source ticks, so full period is 2(n+1)
	wire half_tick = pre_tick && (brg_ff == 8'h00);
	wire running = (state_ff == SSC_SHIFT);

	// ----------------------------------------
	// External clock sampling
	// ----------------------------------------
	// Pin passes three flops; edge counted once second and third agree
	logic ext_lvl_ff;
	wire pin_stable = (pin_ff[1] == pin_ff[2]);
	wire ext_rise = ext_clk && pin_stable && pin_ff[2] && !ext_lvl_ff;
	wire ext_fall = ext_clk && pin_stable && !pin_ff[2] && ext_lvl_ff;
	wire int_rise = !ext_clk && running && half_tick && !sclk_ff;
	wire int_fall = !ext_clk && running && half_tick && sclk_ff;
	wire rise = ext_rise || int_rise;
	wire fall = ext_fall || int_fall;
	// Polarity zero samples on rise, shifts on fall
	wire samp_edge = running && (pol ? fall : rise);
	wire shift_edge = running && (pol ? rise : fall);

	// ----------------------------------------
	// Start and frame control
	// ----------------------------------------
	wire can_start = tx_en && !tx_empty_ff;
	wire rx_go = rx_en && can_start;
	wire cont_go = cont_rx && rx_en && cont_arm_ff;
	wire start = (state_ff == SSC_IDLE) && (can_start || cont_go);
	wire last_samp = samp_edge && (bitcnt_ff == FRAME_BITS - 4'h1);
	wire ovr_hit = samp_edge && (bitcnt_ff == OVR_BIT_NUM - 4'h1) && rx_full_ff;
	wire [7:0] rx_next = msb_first ? {rxsh_ff[6:0], i_rxd} : {i_rxd, rxsh_ff[7:1]};
	wire tx_bit = msb_first ? txsh_ff[7] : txsh_ff[0];
	wire [7:0] tx_next = msb_first ? {txsh_ff[6:0], 1'b0} : {1'b0, txsh_ff[7:1]};
	logic rx_act_ff;
	wire tx_irq_ev = start && can_start && !irs || last_samp && irs && tx_en;
	wire rx_irq_ev = last_samp && rx_act_ff;
	wire [7:0] ev = {5'h00, ovr_hit, rx_irq_ev, tx_irq_ev};
	// Set wins over the write-one clear
	wire [7:0] nxt_sts = (sts_ff & ~(wr_stat ? i_wdata : 8'h00)) | ev;

	logic [7:0] rd_mux;
	always_comb
	begin
		case (i_addr)
			ADDR_MODE: rd_mux = mode_ff;
			ADDR_BAUD: rd_mux = baud_ff;
			ADDR_CTRL: rd_mux = {ctrl_ff[7:4], tx_empty_ff, ctrl_ff[2:0]};
			ADDR_RXB: rd_mux = rxb_ff;
			ADDR_STAT: rd_mux = sts_ff;
			ADDR_MASK: rd_mux = mask_ff;
			default: rd_mux = 8'h00;
		endcase
	end

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	always_ff @(posedge i_clk)
	begin
		if (i_reset)
		begin
			mode_ff <= MODE_RESET;
			baud_ff <= BAUD_RESET;
			ctrl_ff <= CTRL_RESET;
			mask_ff <= 8'h00;
			sts_ff <= 8'h00;
			rdata_ff <= 8'h00;
			irq_ff <= 1'b0;
		end
		else
		begin
			if (wr_mode)
				mode_ff <= i_wdata;
			if (wr_baud)
				baud_ff <= i_wdata;
			if (wr_ctrl)
				ctrl_ff <= {5'h00, i_wdata[2:0]};
			if (wr_mask)
				mask_ff <= i_wdata;
			sts_ff <= nxt_sts;
			rdata_ff <= i_rd ? rd_mux : 8'h00;
			irq_ff <= |(nxt_sts & mask_ff);
		end
	end

	// ----------------------------------------
	// Buffers and shifter
	// ----------------------------------------
	always_ff @(posedge i_clk)
	begin
		if (i_reset)
		begin
			txb_ff <= 8'h00;
			rxb_ff <= 8'h00;
			tx_empty_ff <= 1'b1;
			rx_full_ff <= 1'b0;
			cont_arm_ff <= 1'b0;
			txsh_ff <= 8'h00;
			rxsh_ff <= 8'h00;
			bitcnt_ff <= 4'h0;
			rx_act_ff <= 1'b0;
			state_ff <= SSC_IDLE;
			txd_ff <= 1'b1;
		end
		else
		begin
			if (wr_txb)
			begin
				txb_ff <= i_wdata;
				tx_empty_ff <= 1'b0;
			end
			if (rd_rxb)
			begin
				rx_full_ff <= 1'b0;
				// Arm only in continuous mode, so a stale read cannot start a later frame
				cont_arm_ff <= cont_rx;
			end
			case (state_ff)
				SSC_IDLE:
				begin
					if (start)
					begin
						state_ff <= SSC_LOAD;
						bitcnt_ff <= 4'h0;
						rx_act_ff <= rx_go || cont_go;
						// Dummy all-ones frame on continuous receive with no data
						txsh_ff <= can_start ? txb_ff : 8'hFF;
						if (can_start && !wr_txb)
							tx_empty_ff <= 1'b1;
						if (cont_go && !rd_rxb)
							cont_arm_ff <= 1'b0;
					end
				end
				SSC_LOAD:
				begin
					txd_ff <= tx_bit;
					txsh_ff <= tx_next;
					state_ff <= SSC_SHIFT;
				end
				SSC_SHIFT:
				begin
					if (samp_edge)
					begin
						rxsh_ff <= rx_next;
						bitcnt_ff <= bitcnt_ff + 4'h1;
					end
					if (shift_edge && bitcnt_ff != 4'h0 && bitcnt_ff < FRAME_BITS)
					begin
						txd_ff <= tx_bit;
						txsh_ff <= tx_next;
					end
					if (last_samp)
					begin
						state_ff <= SSC_IDLE;
						if (rx_act_ff)
						begin
							// Overrun leaves received data undefined; latest frame kept
							rxb_ff <= rx_next;
							rx_full_ff <= 1'b1;
						end
					end
				end
				default: state_ff <= SSC_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Clock generation and pin sampling
	// ----------------------------------------
	always_ff @(posedge i_clk)
	begin
		if (i_reset)
		begin
			pre_ff <= 6'h00;
			brg_ff <= 8'h00;
			sclk_ff <= 1'b1;
			sclk_oe_ff <= 1'b1;
			pin_ff <= 3'h7;
			ext_lvl_ff <= 1'b1;
		end
		else
		begin
			pin_ff <= {pin_ff[1:0], i_sclk_in};
			sclk_oe_ff <= !ext_clk;
			if (pin_stable)
				ext_lvl_ff <= pin_ff[2];
			pre_ff <= (!running || pre_tick) ? 6'h00 : pre_ff + 6'h01;
			if (!running)
				brg_ff <= baud_ff;
			else if (pre_tick)
				brg_ff <= (brg_ff == 8'h00) ? baud_ff : brg_ff - 8'h01;
			if (!running || ext_clk)
				sclk_ff <= idle_lvl;
			else if (half_tick)
				sclk_ff <= ~sclk_ff;
		end
	end

	assign o_rdata = rdata_ff;
	assign o_sclk_out = sclk_ff;
	assign o_sclk_oe = sclk_oe_ff;
	assign o_txd = txd_ff;
	assign o_irq = irq_ff;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_frame_len: assert property (@(posedge i_clk) disable iff (i_reset)
		last_samp |-> bitcnt_ff == 4'h7)
		else $error("frame length wrong");
	a_tx_start: assert property (@(posedge i_clk) disable iff (i_reset)
		(state_ff == SSC_IDLE && !can_start && !cont_go) |=> state_ff == SSC_IDLE)
		else $error("transmit started without data");
	a_rx_start: assert property (@(posedge i_clk) disable iff (i_reset)
		(start && (rx_go || cont_go)) |=> rx_act_ff)
		else $error("receive not armed");
	a_tx_irq: assert property (@(posedge i_clk) disable iff (i_reset)
		(start && can_start && !irs) |=> sts_ff[ST_TX_BIT])
		else $error("transmit irq missing");
	a_rx_irq: assert property (@(posedge i_clk) disable iff (i_reset)
		(last_samp && rx_act_ff) |=> sts_ff[ST_RX_BIT] && rx_full_ff)
		else $error("receive irq missing");
	a_overrun: assert property (@(posedge i_clk) disable iff (i_reset)
		(samp_edge && bitcnt_ff == 4'h6 && rx_full_ff) |=> sts_ff[ST_OVR_BIT])
		else $error("overrun not flagged");
	a_idle_clock: assert property (@(posedge i_clk) disable iff (i_reset)
		(state_ff == SSC_IDLE && $past(state_ff) == SSC_IDLE && $stable(pol)) |->
		o_sclk_out == ~pol)
		else $error("clock not idle");
	a_cont_rx: assert property (@(posedge i_clk) disable iff (i_reset)
		(rd_rxb && cont_rx) |=> cont_arm_ff || state_ff != SSC_IDLE)
		else $error("continuous receive not armed");
	a_irq_level: assert property (@(posedge i_clk) disable iff (i_reset)
		##1 o_irq == $past(|(nxt_sts & mask_ff)))
		else $error("irq level wrong");
endmodule : ssc_channel
`default_nettype wire

/* File: sim/ssc_peer.sv */
// Behavioural model of the external synchronous serial peer
`timescale 1ns/1ns
`default_nettype none
module ssc_peer
(
	input wire logic i_sclk,
	input wire logic i_clear,
	input wire logic i_pol,
	input wire logic i_msb,
	input wire logic i_txd,
	input wire logic [7:0] i_send,
	output logic o_rxd,
	output logic [7:0] o_got
);
	logic [2:0] bit_cnt = 3'h0;
	initial o_rxd = 1'b1;
	initial o_got = 8'h00;
	// ----------------------------------------
	// Shift and sample
	// ----------------------------------------
	// Clear realigns the count, as an idle level change looks like an edge
	always @(i_sclk, posedge i_clear)
	begin
		if (i_clear)
			bit_cnt <= 3'h0;
		else if (i_sclk == i_pol)
			o_rxd <= i_send[i_msb ? 3'h7 - bit_cnt : bit_cnt];
		else
		begin
			o_got[i_msb ? 3'h7 - bit_cnt : bit_cnt] <= i_txd;
			bit_cnt <= bit_cnt + 3'h1;
		end
	end
endmodule : ssc_peer
`default_nettype wire

/* File: sim/ssc_channel_tb.sv */
// Self-checking testbench for the synchronous serial channel
`timescale 1ns/1ns
`default_nettype none
module ssc_channel_tb;
	import ssc_pkg::*;
	logic i_clk = 1'b0;
	logic i_reset = 1'b1;
	logic [2:0] i_addr = 3'h0;
	logic [7:0] i_wdata = 8'h00;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic ext_clk = 1'b1;
	logic peer_clear = 1'b0;
	logic [7:0] peer_send = 8'h00;
	logic [7:0] mode = 8'h00;
	logic [7:0] o_rdata;
	logic [7:0] got;
	logic o_sclk_out, o_sclk_oe, o_txd, o_irq, rxd;
	int err_count = 0;
	int tests_run = 0;
	// Pin level: the device drives it only while the internal clock is chosen
	wire logic sclk = o_sclk_oe ? o_sclk_out : ext_clk;
	always #10 i_clk = ~i_clk;
	ssc_channel dut (.i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_sclk_in(sclk), .o_sclk_out(o_sclk_out),
		.o_sclk_oe(o_sclk_oe), .i_rxd(rxd), .o_txd(o_txd), .o_irq(o_irq));
	ssc_peer peer (.i_sclk(sclk), .i_clear(peer_clear), .i_pol(mode[MODE_POL_BIT]),
		.i_msb(mode[MODE_MSB_BIT]), .i_txd(o_txd), .i_send(peer_send), .o_rxd(rxd), .o_got(got));
	// ----------------------------------------
	// Bus and check helpers
	// ----------------------------------------
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		tests_run++;
		if (g !== e)
		begin
			$display("unexpected at %0t: got %h want %h", $time, g, e);
			err_count++;
		end
	endtask : chk
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge i_clk);
		if (a == ADDR_MODE)
			mode <= d;
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [2:0] a, output logic [7:0] v);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		@(negedge i_clk);
		v = o_rdata;
	endtask : rd
	task automatic wait_irq();
		for (int i = 0; i < 3000 && o_irq !== 1'b1; i++)
			@(negedge i_clk);
	endtask : wait_irq
	task automatic setup(input logic [7:0] md, input logic [7:0] c, input logic [7:0] m);
		ext_clk <= ~md[MODE_POL_BIT];
		wr(ADDR_MODE, md);
		wr(ADDR_BAUD, 8'h00);
		wr(ADDR_STAT, 8'h07);
		wr(ADDR_MASK, m);
		wr(ADDR_CTRL, c);
		peer_clear <= 1'b1;
		@(posedge i_clk);
		peer_clear <= 1'b0;
	endtask : setup
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		logic [7:0] v;
		chk(8'(o_txd), 8'h01);
		chk(8'(o_sclk_out), 8'h01);
		chk(8'(o_irq), 8'h00);
		rd(ADDR_MODE, v);
		chk(v, MODE_RESET);
		rd(ADDR_BAUD, v);
		chk(v, BAUD_RESET);
		wr(3'h7, 8'hFF);
		rd(3'h7, v);
		chk(v, 8'h00);
	endtask : t_reset
	task automatic t_frame(input logic [7:0] md, input logic [7:0] n, input int half,
		input logic [7:0] tx, input logic [7:0] rx);
		logic [7:0] v;
		logic last;
		int edges = 0;
		int t1 = 0;
		int t2 = 0;
		setup(md, 8'h03, 8'h02);
		wr(ADDR_BAUD, n);
		peer_send <= rx;
		wr(ADDR_TXB, tx);
		last = o_sclk_out;
		if (md[MODE_CLOCK_DIRECTION_SELECT_BIT])
		begin
			chk(8'(o_sclk_oe), 8'h00);
			repeat (16)
			begin
				repeat (10) @(posedge i_clk);
				ext_clk <= ~ext_clk;
			end
		end
		for (int i = 0; i < 3000 && o_irq !== 1'b1; i++)
		begin
			@(negedge i_clk);
			if (o_sclk_out !== last)
			begin
				edges++;
				t1 = t2;
				t2 = i;
			end
			last = o_sclk_out;
		end
		if (!md[MODE_CLOCK_DIRECTION_SELECT_BIT])
		begin
			chk(8'(edges), 8'h10);
			chk(8'(t2 - t1), 8'(half));
			chk(8'(o_sclk_out), {7'h00, ~md[MODE_POL_BIT]});
		end
		chk(8'(o_irq), 8'h01);
		rd(ADDR_RXB, v);
		chk(v, rx);
		chk(got, tx);
	endtask : t_frame
	task automatic t_gate();
		logic [7:0] v;
		int moved = 0;
		setup(8'h00, 8'h02, 8'h00);
		wr(ADDR_TXB, 8'h11);
		repeat (40)
		begin
			@(negedge i_clk);
			moved += int'(o_sclk_out !== 1'b1);
		end
		chk(8'(moved), 8'h00);
		rd(ADDR_CTRL, v);
		chk(8'(v[3]), 8'h00);
		wr(ADDR_CTRL, 8'h01);
		repeat (60) @(posedge i_clk);
		rd(ADDR_STAT, v);
		chk(v[1:0], 8'h01);
	endtask : t_gate
	task automatic t_irs(input logic irs);
		logic [7:0] v;
		setup(8'h00, {5'h00, irs, 2'h3}, 8'h00);
		wr(ADDR_TXB, 8'h55);
		repeat (3) @(posedge i_clk);
		rd(ADDR_STAT, v);
		chk(8'(v[0]), {7'h00, ~irs});
		chk(8'(o_irq), 8'h00);
		repeat (40) @(posedge i_clk);
		rd(ADDR_STAT, v);
		chk(8'(v[0]), 8'h01);
		wr(ADDR_MASK, 8'h01);
		repeat (2) @(negedge i_clk);
		chk(8'(o_irq), 8'h01);
		wr(ADDR_STAT, 8'h01);
		repeat (2) @(negedge i_clk);
		chk(8'(o_irq), 8'h00);
		rd(ADDR_RXB, v);
	endtask : t_irs
	task automatic t_overrun();
		logic [7:0] v;
		setup(8'h00, 8'h03, 8'h02);
		wr(ADDR_TXB, 8'h33);
		wait_irq();
		wr(ADDR_TXB, 8'h44);
		repeat (40) @(posedge i_clk);
		rd(ADDR_STAT, v);
		chk(8'(v[2]), 8'h01);
		rd(ADDR_RXB, v);
	endtask : t_overrun
	task automatic t_cont();
		logic [7:0] v;
		setup(8'h20, 8'h03, 8'h02);
		peer_send <= 8'h5A;
		rd(ADDR_RXB, v);
		wait_irq();
		rd(ADDR_RXB, v);
		chk(v, 8'h5A);
		chk(got, 8'hFF);
	endtask : t_cont
	task automatic final_report();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : final_report
	initial
	begin
		repeat (16) @(posedge i_clk);
		i_reset <= 1'b0;
		t_reset();
		t_frame(8'h00, 8'h00, 1, 8'hA5, 8'h3C);
		t_frame(8'h18, 8'h02, 3, 8'h81, 8'h7E);
		t_frame(8'h12, 8'h01, 16, 8'h96, 8'hC3);
		t_frame(8'h04, 8'h00, 32, 8'h01, 8'h80);
		t_frame(8'h09, 8'h00, 0, 8'h5A, 8'hF0);
		t_gate();
		t_irs(1'b0);
		t_irs(1'b1);
		t_overrun();
		t_cont();
		final_report();
	end
	initial
	begin
		repeat (20000) @(posedge i_clk);
		err_count++;
		final_report();
	end
endmodule : ssc_channel_tb
`default_nettype wire
